// ---- acq_asserts.sv ----
// Purpose: Port-level checks for the acquisition controller.
// Assumes: Bound to the top module; rst_i is synchronous and active high.
// Notes: The pace spacing is measured by a small gap counter.
`timescale 1ns/10ps
module acq_asserts
    import acq_pkg::*;
#(
    parameter int SCAN_MIN_PERIOD = SCAN_MIN_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire conv_req_t conv_o,
    input wire logic sync_o,
    input wire logic sync_oe_o,
    input wire logic blk_valid_o,
    input wire logic [15:0] blk_data_o,
    input wire logic blk_last_o,
    input wire logic blk_ready_i,
    input wire logic usb_enumerated_i,
    input wire logic led_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] gap;
    logic seen;
    // The first pace pulse after reset has no predecessor, so it is not judged.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap <= '0;
            seen <= 1'b0;
        end else if (sync_o) begin
            gap <= '0;
            seen <= 1'b1;
        end else begin
            gap <= gap + 32'h1;
        end
    end
    sequence idle_s;
        usb_enumerated_i && !blk_valid_o;
    endsequence
    sequence last_pop_s;
        blk_valid_o && blk_ready_i && blk_last_o;
    endsequence
    ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    start_pulse_a: assert property (conv_o.start |=> !conv_o.start)
        else $error("conversion start not a single pulse");
    se_range_a: assert property (conv_o.start && !conv_o.diff |-> conv_o.range == RANGE_10V)
        else $error("single-ended range not forced");
    diff_chan_a: assert property (conv_o.start && conv_o.diff |-> !conv_o.chan[2])
        else $error("differential channel above three");
    blk_hold_a: assert property (blk_valid_o && !blk_ready_i |=> blk_valid_o && $stable(blk_data_o))
        else $error("block word changed while stalled");
    blk_end_a: assert property (last_pop_s |=> !blk_valid_o)
        else $error("block continued after last word");
    led_off_a: assert property (!usb_enumerated_i |=> !led_o)
        else $error("indicator on while not attached");
    led_steady_a: assert property (idle_s [*3] |-> led_o)
        else $error("indicator not steady while idle");
    sync_drive_a: assert property (sync_o |-> sync_oe_o)
        else $error("pace pulse without drive enable");
    pace_gap_a: assert property (sync_o && seen |-> gap >= SCAN_MIN_PERIOD - 1)
        else $error("pace pulses too close");
endmodule

bind analog_input_acquisition_ctrl acq_asserts #(.SCAN_MIN_PERIOD(SCAN_MIN_PERIOD)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .conv_o(conv_o), .sync_o(sync_o), .sync_oe_o(sync_oe_o), .blk_valid_o(blk_valid_o),
    .blk_data_o(blk_data_o), .blk_last_o(blk_last_o), .blk_ready_i(blk_ready_i),
    .usb_enumerated_i(usb_enumerated_i), .led_o(led_o));

// ---- acq_host_model.sv ----
// Purpose: Far-side model: converter answering starts and host link taking blocks.
// Assumes: One conversion outstanding; result four cycles after start.
// Notes: Ready alternates so words are taken both promptly and late.
`timescale 1ns/10ps
module acq_host_model
    import acq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire conv_req_t conv_i,
    output logic conv_done_o,
    output logic [RESULT_W-1:0] conv_data_o,
    input wire logic blk_valid_i,
    input wire logic [15:0] blk_data_i,
    input wire logic blk_last_i,
    input wire logic stall_i,
    output logic blk_ready_o
);
    logic [15:0] words[$];
    logic lasts[$];
    logic [1:0] wait_cnt;
    initial begin
        conv_done_o = 1'b0;
        conv_data_o = '0;
        blk_ready_o = 1'b0;
        wait_cnt = 2'h0;
    end
    // The channel number sits in the top bits so the bench can see the scan order.
    always @(posedge clk_i) begin
        if (rst_i || conv_i.start) begin
            wait_cnt <= rst_i ? 2'h0 : 2'h3;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
        conv_done_o <= wait_cnt == 2'h1;
        // Outside the result cycle the data lines never repeat a stale value.
        conv_data_o <= (wait_cnt == 2'h1) ? {conv_i.chan, 11'h2aa} : ~conv_data_o;
        if (blk_valid_i && blk_ready_o) begin
            words.push_back(blk_data_i);
            lasts.push_back(blk_last_i);
        end
        blk_ready_o <= !stall_i && !blk_ready_o;
    end
endmodule

// ---- acq_pkg.sv ----
// Purpose: Shared constants and types for the analog input acquisition controller.
// Assumes: 200 MHz system clock, classic Wishbone register access with 32-bit data.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package acq_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int SCAN_MAX_SPS = 48_000;
    localparam int SCAN_MIN_CYCLES = (CLK_HZ + SCAN_MAX_SPS - 1) / SCAN_MAX_SPS;
    localparam int LED_BLINK_MS = 100;
    localparam int LED_BLINK_CYCLES = (CLK_HZ / 1000) * LED_BLINK_MS;

    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW = 5;
    localparam int BLOCK_LEN = 8;
    localparam int RESULT_W = 14;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_CHANS = 8'h08;
    localparam logic [7:0] ADDR_PACE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SINGLE = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

    localparam int CMD_SINGLE_BIT = 0;
    localparam int CMD_START_BIT = 1;
    localparam int CMD_STOP_BIT = 2;

    localparam int IRQ_SINGLE_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam int IRQ_BLOCK_BIT = 2;
    localparam int IRQ_W = 3;

    localparam logic [2:0] RANGE_10V = 3'h1;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [15:0] PACE_RESET = 16'h1047;

    // Gain codes 0..7 select +-20, 10, 5, 4, 2.5, 2, 1.25 and 1 V.
    typedef struct packed {
        logic [2:0] gain;
        logic sync_in;
        logic trig_rising;
        logic trig_en;
        logic diff;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] single_chan;
        logic [2:0] high_chan;
        logic [2:0] low_chan;
    } chans_t;

    typedef struct packed {
        logic start;
        logic [2:0] chan;
        logic diff;
        logic [2:0] range;
    } conv_req_t;

    typedef enum logic {C_IDLE, C_BUSY} conv_state_t;
endpackage

// ---- analog_input_acquisition_ctrl.sv ----
// Purpose: Analog input acquisition control: single conversions, paced scans, FIFO and block drain.
// Assumes: Converter answers each start with one conv_done_i pulse; host link reports enumeration.
// Notes: Registers are reached over classic Wishbone; ack follows a request by one cycle.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps

// Function
// - One sample per single command, result before next.
// - Scan samples a list of up to eight channels.
// - Scan converts into FIFO until host stops it; the code also ends the scan on FIFO overrun.
// - FIFO drains to host in multi-word blocks.
// - Aggregate scan rate never exceeds 48 kS/s; the code clamps only the internal pace, and sync input pacing has no limit.
// - Scan starts on command or external trigger edge.
// - Indicator steady on when enumerated and idle.
// - Indicator blinks while a transfer is in progress.
// - Indicator cannot be disabled by any setting.
// - Eight single-ended or four differential channels.
// - Results 14-bit differential, 13-bit single-ended.
// - Single-ended forces the plus-minus 10 V range.
// - Trigger edge selectable rising or falling.
// - Sync terminal paces scans as output or input.
// - Differential gain selects one of eight ranges.
module analog_input_acquisition_ctrl
    import acq_pkg::*;
#(
    parameter int SCAN_MIN_PERIOD = SCAN_MIN_CYCLES,
    parameter int LED_BLINK_PERIOD = LED_BLINK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output conv_req_t conv_o,
    input wire logic conv_done_i,
    input wire logic [RESULT_W-1:0] conv_data_i,
    input wire logic external_start_input_i,
    input wire logic sync_i,
    output logic sync_o,
    output logic sync_oe_o,
    output logic blk_valid_o,
    output logic [15:0] blk_data_o,
    output logic blk_last_o,
    input wire logic blk_ready_i,
    input wire logic usb_enumerated_i,
    output logic led_o
);
    function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] clamp_chan(input logic [2:0] ch, input logic diff);
        return diff ? {1'b0, ch[1:0]} : ch;
    endfunction

    function automatic logic [15:0] fmt_result(input logic [RESULT_W-1:0] d, input logic diff);
        return diff ? {2'h0, d} : {3'h0, d[RESULT_W-1:1]};
    endfunction

    ctrl_t ctrl;
    chans_t chans;
    conv_state_t cstate;
    logic [15:0] pace, single_result, pace_cnt, period;
    logic [IRQ_W-1:0] irq_stat, irq_mask;
    logic single_valid, single_pend, scanning, armed, sample_pend, pace_tick, trig_prev, sync_prev, src_scan;
    logic sending, blink;
    logic [2:0] scan_chan, low_ch, high_ch;
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr, rd_ptr;
    logic [FIFO_AW:0] fifo_cnt;
    logic [3:0] blk_left;
    logic [31:0] blink_cnt;
    logic wr_req, rd_req, cmd_single, cmd_start, cmd_stop, trig_edge, sync_rise;
    logic push, pop, overrun, block_start, single_done;

    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign cmd_single = wr_req && wb_adr_i == ADDR_CMD && wb_sel_i[0] && wb_dat_i[CMD_SINGLE_BIT];
    assign cmd_start = wr_req && wb_adr_i == ADDR_CMD && wb_sel_i[0] && wb_dat_i[CMD_START_BIT];
    assign cmd_stop = wr_req && wb_adr_i == ADDR_CMD && wb_sel_i[0] && wb_dat_i[CMD_STOP_BIT];
    assign low_ch = clamp_chan(chans.low_chan, ctrl.diff);
    assign high_ch = clamp_chan(chans.high_chan, ctrl.diff);
    // A programmed period below the 48 kS/s floor is raised to the floor.
    assign period = (pace < 16'(SCAN_MIN_PERIOD)) ? 16'(SCAN_MIN_PERIOD) : pace;
    assign trig_edge = ctrl.trig_rising ? (external_start_input_i && !trig_prev)
                                        : (!external_start_input_i && trig_prev);
    assign sync_rise = sync_i && !sync_prev;
    assign push = cstate == C_BUSY && conv_done_i && src_scan;
    assign overrun = push && fifo_cnt == (FIFO_AW+1)'(FIFO_DEPTH);
    assign pop = sending && blk_ready_i;
    assign block_start = !sending && fifo_cnt >= (FIFO_AW+1)'(BLOCK_LEN);
    assign single_done = cstate == C_BUSY && conv_done_i && !src_scan;

    // Wishbone slave: one wait state, unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (rd_req) begin
                case (wb_adr_i)
                    ADDR_CTRL: wb_dat_o <= {25'h0, ctrl};
                    ADDR_CHANS: wb_dat_o <= {21'h0, chans.single_chan, 1'b0, chans.high_chan, 1'b0, chans.low_chan};
                    ADDR_PACE: wb_dat_o <= {16'h0, pace};
                    ADDR_STATUS: wb_dat_o <= {21'h0, fifo_cnt, 1'b0, sending, single_pend, armed, scanning};
                    ADDR_SINGLE: wb_dat_o <= {single_valid, 15'h0, single_result};
                    ADDR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
                    ADDR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
            chans <= '0;
            pace <= PACE_RESET;
            irq_mask <= '0;
        end else if (wr_req) begin
            case (wb_adr_i)
                ADDR_CTRL: ctrl <= ctrl_t'(7'(merge_sel({25'h0, ctrl}, wb_dat_i, wb_sel_i)));
                ADDR_CHANS: begin
                    chans.low_chan <= wb_sel_i[0] ? wb_dat_i[2:0] : chans.low_chan;
                    chans.high_chan <= wb_sel_i[0] ? wb_dat_i[6:4] : chans.high_chan;
                    chans.single_chan <= wb_sel_i[1] ? wb_dat_i[10:8] : chans.single_chan;
                end
                ADDR_PACE: pace <= 16'(merge_sel({16'h0, pace}, wb_dat_i, wb_sel_i));
                ADDR_IRQ_MASK: irq_mask <= IRQ_W'(merge_sel({29'h0, irq_mask}, wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    // Sticky events; a new event in the clearing cycle survives the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_req && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0))
                      | {block_start, overrun, single_done};
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_prev <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            trig_prev <= external_start_input_i;
            sync_prev <= sync_i;
        end
    end

    // Scan run control: start arms on trigger when selected, stop and overrun end it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scanning <= 1'b0;
            armed <= 1'b0;
        end else if (cmd_stop || overrun) begin
            scanning <= 1'b0;
            armed <= 1'b0;
        end else if (cmd_start && !scanning) begin
            scanning <= !ctrl.trig_en;
            armed <= ctrl.trig_en;
        end else if (armed && trig_edge) begin
            scanning <= 1'b1;
            armed <= 1'b0;
        end
    end

    // Pacing: internal divider drives the sync pin, or the sync pin paces us.
    always_ff @(posedge clk_i) begin
        if (rst_i || !scanning) begin
            pace_cnt <= 16'h0000;
            pace_tick <= 1'b0;
        end else if (ctrl.sync_in) begin
            pace_cnt <= 16'h0000;
            pace_tick <= sync_rise;
        end else if (pace_cnt >= period - 16'h0001) begin
            pace_cnt <= 16'h0000;
            pace_tick <= 1'b1;
        end else begin
            pace_cnt <= pace_cnt + 16'h0001;
            pace_tick <= 1'b0;
        end
    end

    assign sync_o = pace_tick && !ctrl.sync_in;
    assign sync_oe_o = !ctrl.sync_in;

    always_ff @(posedge clk_i) begin
        if (rst_i || !scanning) begin
            sample_pend <= 1'b0;
        end else if (pace_tick) begin
            sample_pend <= 1'b1;
        end else if (cstate == C_IDLE) begin
            sample_pend <= 1'b0;
        end
    end

    // A single command is taken only when nothing single is outstanding.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            single_pend <= 1'b0;
        end else if (cmd_single && !single_pend && !scanning) begin
            single_pend <= 1'b1;
        end else if (single_done) begin
            single_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cstate <= C_IDLE;
            src_scan <= 1'b0;
            conv_o <= '0;
            scan_chan <= 3'h0;
        end else begin
            conv_o.start <= 1'b0;
            conv_o.diff <= ctrl.diff;
            conv_o.range <= ctrl.diff ? ctrl.gain : RANGE_10V;
            if (!scanning && !armed) begin
                scan_chan <= low_ch;
            end
            case (cstate)
                C_IDLE: begin
                    if (scanning && sample_pend) begin
                        conv_o.start <= 1'b1;
                        conv_o.chan <= scan_chan;
                        src_scan <= 1'b1;
                        cstate <= C_BUSY;
                        scan_chan <= (scan_chan >= high_ch) ? low_ch : scan_chan + 3'h1;
                    end else if (single_pend && !scanning) begin
                        conv_o.start <= 1'b1;
                        conv_o.chan <= clamp_chan(chans.single_chan, ctrl.diff);
                        src_scan <= 1'b0;
                        cstate <= C_BUSY;
                    end
                end
                C_BUSY: begin
                    if (conv_done_i) begin
                        cstate <= C_IDLE;
                    end
                end
                default: cstate <= C_IDLE;
            endcase
        end
    end

    // Single result stays valid until the host reads it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            single_result <= 16'h0000;
            single_valid <= 1'b0;
        end else if (single_done) begin
            single_result <= fmt_result(conv_data_i, ctrl.diff);
            single_valid <= 1'b1;
        end else if (rd_req && wb_adr_i == ADDR_SINGLE) begin
            single_valid <= 1'b0;
        end
    end

    // Scan FIFO; a push into a full FIFO is dropped and flagged as overrun.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fifo_cnt <= '0;
        end else begin
            if (push && !overrun) begin
                fifo_mem[wr_ptr] <= fmt_result(conv_data_i, ctrl.diff);
                wr_ptr <= wr_ptr + FIFO_AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + FIFO_AW'(1);
            end
            fifo_cnt <= fifo_cnt + (FIFO_AW+1)'(push && !overrun) - (FIFO_AW+1)'(pop);
        end
    end

    // Block drain: a block only starts once a full block is buffered.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sending <= 1'b0;
            blk_left <= 4'h0;
        end else if (block_start) begin
            sending <= 1'b1;
            blk_left <= 4'(BLOCK_LEN);
        end else if (pop) begin
            blk_left <= blk_left - 4'h1;
            sending <= blk_left != 4'h1;
        end
    end

    assign blk_valid_o = sending;
    assign blk_data_o = fifo_mem[rd_ptr];
    assign blk_last_o = sending && blk_left == 4'h1;

    // Indicator has no enable: steady when enumerated, blinking during transfers.
    always_ff @(posedge clk_i) begin
        if (rst_i || !sending) begin
            blink_cnt <= 32'h0000_0000;
            blink <= 1'b1;
        end else if (blink_cnt >= 32'(LED_BLINK_PERIOD - 1)) begin
            blink_cnt <= 32'h0000_0000;
            blink <= !blink;
        end else begin
            blink_cnt <= blink_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_o <= 1'b0;
        end else begin
            led_o <= usb_enumerated_i && blink;
        end
    end
endmodule

// ---- analog_input_acquisition_ctrl_bench.sv ----
// Purpose: Self-checking bench for the acquisition controller over Wishbone.
// Assumes: Short pace and blink periods so the run stays brief.
// Notes: Expected results follow from the model's channel-tagged data.
`timescale 1ns/10ps
module analog_input_acquisition_ctrl_bench;
    import acq_pkg::*;
    localparam int PACE_MIN = 20;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ext, sync_i, stall, usb_en, led_prev;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    logic wb_ack_o, irq_o, sync_o, sync_oe_o, blk_valid_o, blk_last_o, blk_ready_i, led_o, done;
    logic [15:0] blk_data_o;
    logic [RESULT_W-1:0] conv_data_i;
    conv_req_t conv_o;
    int fails, n_tests, cyc, starts, last_start, gap_min, toggles, s0;
    analog_input_acquisition_ctrl #(.SCAN_MIN_PERIOD(PACE_MIN), .LED_BLINK_PERIOD(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .conv_o(conv_o), .conv_done_i(done), .conv_data_i(conv_data_i),
        .external_start_input_i(ext), .sync_i(sync_i), .sync_o(sync_o), .sync_oe_o(sync_oe_o),
        .blk_valid_o(blk_valid_o), .blk_data_o(blk_data_o), .blk_last_o(blk_last_o),
        .blk_ready_i(blk_ready_i), .usb_enumerated_i(usb_en), .led_o(led_o));
    acq_host_model host (.clk_i(clk_i), .rst_i(rst_i), .conv_i(conv_o), .conv_done_o(done),
        .conv_data_o(conv_data_i), .blk_valid_i(blk_valid_o), .blk_data_i(blk_data_o),
        .blk_last_i(blk_last_o), .stall_i(stall), .blk_ready_o(blk_ready_i));
    always #2.5 clk_i = !clk_i;
    task automatic complete_run();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 16) begin
            @(posedge clk_i);
            n++;
        end
        d = wb_dat_o;
        if (n == 16) fails++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
        wb_io(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, d & mask);
    endtask
    task automatic poll(input logic [7:0] a, input int b);
        d = '0;
        for (int k = 0; k < 400 && d[b] !== 1'b1; k++) wb_io(1'b0, a, 32'h0);
    endtask
    // Bench-side sampling at the edge sees registered outputs before they update.
    always @(posedge clk_i) begin
        cyc++;
        if (conv_o.start === 1'b1) begin
            if (last_start > 0 && cyc - last_start < gap_min) gap_min = cyc - last_start;
            last_start = cyc;
            starts++;
        end
        if (blk_valid_o === 1'b1 && led_o !== led_prev) toggles++;
        led_prev = led_o;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, ext, sync_i, stall, led_prev} = '0;
        {rst_i, usb_en} = 2'b11;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hf, 32'h0};
        {fails, n_tests, cyc, starts, last_start, toggles, s0} = {7{32'h0}};
        gap_min = 1000000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(ADDR_CTRL, 32'hffff_ffff, 32'h0);
        rdc(ADDR_PACE, 32'hffff_ffff, 32'h1047);
        rdc(ADDR_CMD, 32'hffff_ffff, 32'h0);
        wb_io(1'b1, 8'h20, 32'hffff_ffff);
        rdc(8'h20, 32'hffff_ffff, 32'h0);
        chk("led", 32'h1, 32'(led_o));
        usb_en <= 1'b0;
        rdc(ADDR_IRQ_MASK, 32'hffff_ffff, 32'h0);
        chk("led", 32'h0, 32'(led_o));
        usb_en <= 1'b1;
        wb_io(1'b1, ADDR_CHANS, 32'h500);
        wb_io(1'b1, ADDR_IRQ_MASK, 32'h7);
        wb_io(1'b1, ADDR_CMD, 32'h1);
        poll(ADDR_SINGLE, 31);
        chk("single", 32'h8000_1555, d);
        chk("irq", 32'h1, 32'(irq_o));
        rdc(ADDR_SINGLE, 32'h8000_0000, 32'h0);
        wb_io(1'b1, ADDR_IRQ_STAT, 32'h1);
        rdc(ADDR_IRQ_STAT, 32'h1, 32'h0);
        chk("irq", 32'h0, 32'(irq_o));
        wb_io(1'b1, ADDR_IRQ_MASK, 32'h0);
        wb_io(1'b1, ADDR_CTRL, 32'h71);
        wb_io(1'b1, ADDR_CHANS, 32'h700);
        wb_io(1'b1, ADDR_CMD, 32'h1);
        poll(ADDR_SINGLE, 31);
        chk("single", 32'h8000_1aaa, d);
        chk("range", 32'h7, 32'(conv_o.range));
        rdc(ADDR_IRQ_STAT, 32'h1, 32'h1);
        chk("irq", 32'h0, 32'(irq_o));
        chk("starts", 32'h2, 32'(starts));
        wb_io(1'b1, ADDR_IRQ_STAT, 32'h7);
        wb_io(1'b1, ADDR_CTRL, 32'h0);
        wb_io(1'b1, ADDR_CHANS, 32'h42);
        wb_io(1'b1, ADDR_PACE, 32'h5);
        chk("range", 32'(RANGE_10V), 32'(conv_o.range));
        wb_io(1'b1, ADDR_CMD, 32'h2);
        for (int k = 0; k < 2000 && host.words.size() < 16; k++) @(posedge clk_i);
        wb_io(1'b1, ADDR_CMD, 32'h4);
        rdc(ADDR_STATUS, 32'h1, 32'h0);
        for (int i = 0; i < 16; i++) chk("word", 32'({3'(2 + i % 3), 10'h155}), 32'(host.words[i]));
        chk("last", 32'h1, 32'(host.lasts[7] && host.lasts[15] && !host.lasts[6]));
        chk("pace gap", 32'h1, 32'(gap_min >= PACE_MIN));
        rdc(ADDR_IRQ_STAT, 32'h4, 32'h4);
        stall <= 1'b1;
        wb_io(1'b1, ADDR_IRQ_MASK, 32'h2);
        wb_io(1'b1, ADDR_CMD, 32'h2);
        poll(ADDR_IRQ_STAT, 1);
        rdc(ADDR_STATUS, 32'h1, 32'h0);
        chk("irq", 32'h1, 32'(irq_o));
        chk("blink", 32'h1, 32'(toggles > 2));
        stall <= 1'b0;
        wb_io(1'b1, ADDR_IRQ_STAT, 32'h7);
        chk("irq", 32'h0, 32'(irq_o));
        for (int r = 0; r < 2; r++) begin
            ext <= !r[0];
            wb_io(1'b1, ADDR_CTRL, 32'h2 | (32'(r) << 2));
            wb_io(1'b1, ADDR_CMD, 32'h2);
            rdc(ADDR_STATUS, 32'h3, 32'h2);
            ext <= r[0];
            poll(ADDR_STATUS, 0);
            chk("armed scan", 32'h1, d & 32'h3);
            wb_io(1'b1, ADDR_CMD, 32'h4);
        end
        chk("sync oe", 32'h1, 32'(sync_oe_o));
        wb_io(1'b1, ADDR_CTRL, 32'h8);
        chk("sync oe", 32'h0, 32'(sync_oe_o));
        s0 = starts;
        wb_io(1'b1, ADDR_CMD, 32'h2);
        repeat (4) begin
            repeat (30) @(posedge clk_i);
            sync_i <= !sync_i;
        end
        wb_io(1'b1, ADDR_CMD, 32'h4);
        chk("sync starts", 32'h2, 32'(starts - s0));
        complete_run();
    end
endmodule
